/* File: logic/vmfd_decoder.sv */
// Purpose: classify and validate vm control structure field encodings
// Assumes: one clock, synchronous active-low reset, inputs synchronous
// Notes:   one decode per cycle, answer one cycle later
//
// Function
// [RULE1] width code 2 in bits 14:13 means a 32-bit field
// [RULE2] width code 3 means a natural-width field, 64 bits here
// [RULE3] 32-bit and natural fields are full access only, encodings even
// [RULE4] area code 0 in bits 11:10 is the control area
// [RULE5] area code 1 is the read-only exit data area
// [RULE6] area code 2 is the guest state area
// [RULE7] area code 3 is the host state area
// [RULE8] bits 9:1 hold the index within width and area
// [RULE9] sixteen 32-bit control fields from 4000h to 401Eh
// [RULE10] threshold and secondary controls exist only if their capability is set
// [RULE11] eight 32-bit exit data fields from 4400h to 440Eh
// [RULE12] 32-bit guest fields from 4800h to 482Ah
// [RULE13] vm entry clears upper 16 bits of guest table limits
// [RULE14] one 32-bit host field, the fast syscall code selector, at 4C00h
// [RULE15] natural control fields from 6000h, target value 0 at 6008h
// [RULE16] extra target values follow the first four consecutively
// [RULE17] natural exit data fields from 6400h to 640Ah
// [RULE18] natural guest fields from 6800h to 6826h
// [RULE19] vm entry clears upper 32 bits of guest segment bases
// [RULE20] bits 31:15 and bit 12 must be zero
// [RULE21] width 1 is a 64-bit field with high half access, 0 is 16-bit
// [RULE22] bad reserved bits, odd full-only or missing index give invalid
// [RULE23] writes to the exit data area are refused
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module vmfd_decoder #(
    parameter int unsigned CR3_TARGETS = vmfd_pkg::CR3_TGT_DEF
) (
    input  wire logic                clk_sys_i,
    input  wire logic                nrst_i,
    input  wire vmfd_pkg::vmfd_bus_t bus_i,
    output var  logic [31:0]         bus_rdata_o,
    input  wire logic                req_valid_i,
    input  wire logic                req_write_i,
    input  wire logic [31:0]         req_enc_i,
    output var  logic                rsp_valid_o,
    output var  vmfd_pkg::vmfd_dec_t rsp_o,
    input  wire logic                entry_valid_i,
    input  wire logic [31:0]         entry_enc_i,
    input  wire logic [63:0]         entry_data_i,
    output var  logic                entry_valid_o,
    output var  logic [63:0]         entry_data_o
);

    ////////////////////////////////////////////////////////////////////////
    // decode function

    function automatic vmfd_pkg::vmfd_dec_t decode(
        input logic [31:0] enc,
        input logic        wr,
        input logic        tpr_ok,
        input logic        sec_ok
    );
        vmfd_pkg::vmfd_dec_t d;
        logic [8:0]          lim;
        d         = '0;
        lim       = 9'h000;
        d.width   = enc[vmfd_pkg::WID_HI:vmfd_pkg::WID_LO]; // [RULE1] [RULE2] [RULE21]
        d.area    = enc[vmfd_pkg::AREA_HI:vmfd_pkg::AREA_LO]; // [RULE4] [RULE5] [RULE6] [RULE7]
        d.index   = enc[vmfd_pkg::IDX_HI:vmfd_pkg::IDX_LO]; // [RULE8]
        d.hi_acc  = enc[vmfd_pkg::ACC_BIT] & (d.width == vmfd_pkg::WID_64); // [RULE21]
        d.rsv_err = (enc & vmfd_pkg::RSV_MASK) != 32'h0000_0000; // [RULE20]
        d.odd_err = enc[vmfd_pkg::ACC_BIT] & (d.width != vmfd_pkg::WID_64); // [RULE3]
        unique case ({d.width, d.area})
            {vmfd_pkg::WID_32, vmfd_pkg::AREA_CTL}:
                lim = vmfd_pkg::CNT_32_CTL; // [RULE9]
            {vmfd_pkg::WID_32, vmfd_pkg::AREA_RO}:
                lim = vmfd_pkg::CNT_32_RO; // [RULE11]
            {vmfd_pkg::WID_32, vmfd_pkg::AREA_GST}:
                lim = vmfd_pkg::CNT_32_GST; // [RULE12]
            {vmfd_pkg::WID_32, vmfd_pkg::AREA_HOST}:
                lim = vmfd_pkg::CNT_32_HOST; // [RULE14]
            {vmfd_pkg::WID_NAT, vmfd_pkg::AREA_CTL}:
                lim = vmfd_pkg::CNT_NAT_FIX + 9'(CR3_TARGETS); // [RULE15] [RULE16]
            {vmfd_pkg::WID_NAT, vmfd_pkg::AREA_RO}:
                lim = vmfd_pkg::CNT_NAT_RO; // [RULE17]
            {vmfd_pkg::WID_NAT, vmfd_pkg::AREA_GST}:
                lim = vmfd_pkg::CNT_NAT_GST; // [RULE18]
            default:
                lim = 9'h000;
        endcase
        d.idx_err = d.index >= lim; // [RULE22]
        if ((d.width == vmfd_pkg::WID_32) && (d.area == vmfd_pkg::AREA_CTL))
        begin
            if ((d.index == vmfd_pkg::IDX_TPR_THR) && !tpr_ok)
            begin
                d.idx_err = 1'b1; // [RULE10]
            end
            if ((d.index == vmfd_pkg::IDX_SEC_CTL) && !sec_ok)
            begin
                d.idx_err = 1'b1; // [RULE10]
            end
        end
        d.ok      = !(d.rsv_err | d.odd_err | d.idx_err); // [RULE22]
        d.wr_deny = wr & (d.area == vmfd_pkg::AREA_RO); // [RULE23]
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [1:0]          cfg_reg;
    logic [15:0]         cnt_reg;
    logic [15:0]         cnt_next;
    logic [31:0]         rdata_next;
    vmfd_pkg::vmfd_dec_t req_dec;
    vmfd_pkg::vmfd_dec_t ent_dec;
    logic                lim_clr;
    logic                base_clr;
    logic [63:0]         entry_next;
    logic                tpr_cap;
    logic                sec_cap;

    assign tpr_cap = cfg_reg[vmfd_pkg::CFG_TPR_BIT];
    assign sec_cap = cfg_reg[vmfd_pkg::CFG_SEC_BIT];

    ////////////////////////////////////////////////////////////////////////
    // request decode

    assign req_dec = decode(req_enc_i, req_write_i, tpr_cap, sec_cap);

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            rsp_valid_o <= 1'b0;
            rsp_o       <= '0;
        end
        else
        begin
            rsp_valid_o <= req_valid_i;
            if (req_valid_i)
            begin
                rsp_o <= req_dec;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // vm entry clearing of over-wide guest fields

    assign ent_dec  = decode(entry_enc_i, 1'b0, tpr_cap, sec_cap);
    assign lim_clr  = ent_dec.ok
                    && (ent_dec.width == vmfd_pkg::WID_32)
                    && (ent_dec.area == vmfd_pkg::AREA_GST)
                    && ((ent_dec.index == vmfd_pkg::IDX_GLOBAL_DESCRIPTOR_TABLE_REG_LIM)
                     || (ent_dec.index == vmfd_pkg::IDX_INTERRUPT_DESCRIPTOR_TABLE_REG_LIM));
    assign base_clr = ent_dec.ok
                    && (ent_dec.width == vmfd_pkg::WID_NAT)
                    && (ent_dec.area == vmfd_pkg::AREA_GST)
                    && (ent_dec.index >= vmfd_pkg::IDX_BASE_LO)
                    && (ent_dec.index <= vmfd_pkg::IDX_BASE_HI);

    always_comb
    begin
        entry_next = entry_data_i;
        if (lim_clr)
        begin
            entry_next = entry_data_i & vmfd_pkg::LIM_MASK; // [RULE13]
        end
        else if (base_clr)
        begin
            entry_next = entry_data_i & vmfd_pkg::BASE_MASK; // [RULE19]
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            entry_valid_o <= 1'b0;
            entry_data_o  <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            entry_valid_o <= entry_valid_i;
            if (entry_valid_i)
            begin
                entry_data_o <= entry_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            cfg_reg <= vmfd_pkg::CFG_RST;
        end
        else if (bus_i.we && (bus_i.addr == vmfd_pkg::REG_CFG))
        begin
            cfg_reg <= bus_i.wdata[1:0];
        end
    end

    // invalid counter, a clear and a new event in the same cycle leave a count of one
    always_comb
    begin
        cnt_next = cnt_reg;
        if (bus_i.we && (bus_i.addr == vmfd_pkg::REG_CNT))
        begin
            cnt_next = 16'h0000;
        end
        if (req_valid_i && !req_dec.ok && (cnt_next != 16'hFFFF))
        begin
            cnt_next = cnt_next + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            cnt_reg <= 16'h0000;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (bus_i.re)
        begin
            unique case (bus_i.addr)
                vmfd_pkg::REG_CFG:
                    rdata_next = {30'h0000_0000, cfg_reg};
                vmfd_pkg::REG_STAT:
                    rdata_next = {13'h0000, rsp_o};
                vmfd_pkg::REG_CNT:
                    rdata_next = {16'h0000, cnt_reg};
                default:
                    rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            bus_rdata_o <= 32'h0000_0000;
        end
        else
        begin
            bus_rdata_o <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_req(logic [31:0] e);
        req_valid_i && (req_enc_i == e);
    endsequence

    sequence s_entry(logic [31:0] e);
        entry_valid_i && (entry_enc_i == e);
    endsequence

    sequence s_req_wr(logic [31:0] e);
        req_valid_i && req_write_i && (req_enc_i == e);
    endsequence

    sequence s_req_past_end(logic [1:0] w, logic [1:0] a, logic [8:0] n);
        req_valid_i && (req_enc_i[vmfd_pkg::WID_HI:vmfd_pkg::WID_LO] == w)
            && (req_enc_i[vmfd_pkg::AREA_HI:vmfd_pkg::AREA_LO] == a)
            && (req_enc_i[vmfd_pkg::IDX_HI:vmfd_pkg::IDX_LO] >= n);
    endsequence

    a_width_class: assert property ( // [RULE1] [RULE2] [RULE21]
        req_valid_i |=> rsp_valid_o
            && (rsp_o.width == $past(req_enc_i[vmfd_pkg::WID_HI:vmfd_pkg::WID_LO])))
        else $error("width class wrong");

    a_area_index: assert property ( // [RULE4] [RULE5] [RULE6] [RULE7] [RULE8]
        req_valid_i |=> (rsp_o.area == $past(req_enc_i[vmfd_pkg::AREA_HI:vmfd_pkg::AREA_LO]))
            && (rsp_o.index == $past(req_enc_i[vmfd_pkg::IDX_HI:vmfd_pkg::IDX_LO])))
        else $error("area or index wrong");

    a_reserved_bits: assert property ( // [RULE20] [RULE22]
        req_valid_i && ((req_enc_i & vmfd_pkg::RSV_MASK) != 32'h0000_0000)
            |=> rsp_valid_o && rsp_o.rsv_err && !rsp_o.ok)
        else $error("reserved bits accepted");

    a_odd_full: assert property ( // [RULE3]
        req_valid_i && req_enc_i[vmfd_pkg::ACC_BIT] && req_enc_i[vmfd_pkg::WID_HI]
            |=> !rsp_o.ok && rsp_o.odd_err)
        else $error("odd full-only encoding accepted");

    a_tpr_gate: assert property ( // [RULE10] [RULE9]
        s_req(vmfd_pkg::ENC_TPR_THR) |=> (rsp_o.ok == $past(tpr_cap)))
        else $error("threshold field gating wrong");

    a_host_field: assert property ( // [RULE14]
        s_req(vmfd_pkg::ENC_HOST_CS) |=> rsp_o.ok && !rsp_o.idx_err)
        else $error("host field refused");

    a_host_single: assert property ( // [RULE14]
        s_req(vmfd_pkg::ENC_HOST_CS + 32'h0000_0002) |=> rsp_o.idx_err && !rsp_o.ok)
        else $error("second host field accepted");

    a_cr3_target: assert property ( // [RULE15] [RULE16]
        s_req(vmfd_pkg::ENC_CR3_TGT0) |=> rsp_o.ok
            && (rsp_o.index == vmfd_pkg::CNT_NAT_FIX))
        else $error("first target value misplaced");

    a_ro_write: assert property ( // [RULE23] [RULE11]
        s_req_wr(vmfd_pkg::ENC_EXIT_RSN) |=> rsp_o.ok && rsp_o.wr_deny)
        else $error("write to exit data not refused");

    a_limit_clear: assert property ( // [RULE13]
        s_entry(vmfd_pkg::ENC_GLOBAL_DESCRIPTOR_TABLE_REG_LIM) |=> entry_valid_o
            && (entry_data_o == ($past(entry_data_i) & vmfd_pkg::LIM_MASK)))
        else $error("table limit upper bits kept");

    a_base_clear: assert property ( // [RULE19]
        s_entry(vmfd_pkg::ENC_ES_BASE) |=> entry_valid_o
            && (entry_data_o[63:32] == 32'h0000_0000)
            && (entry_data_o[31:0] == $past(entry_data_i[31:0])))
        else $error("segment base upper bits kept");

    a_sec_gate: assert property ( // [RULE10] [RULE9]
        s_req(vmfd_pkg::ENC_TPR_THR + 32'h0000_0002) |=> (rsp_o.ok == $past(sec_cap)))
        else $error("secondary controls gating wrong");

    a_ro_end: assert property ( // [RULE11]
        s_req_past_end(vmfd_pkg::WID_32, vmfd_pkg::AREA_RO, vmfd_pkg::CNT_32_RO) |=> rsp_o.idx_err)
        else $error("exit data index past the end accepted");

    a_guest_end: assert property ( // [RULE12]
        s_req_past_end(vmfd_pkg::WID_32, vmfd_pkg::AREA_GST, vmfd_pkg::CNT_32_GST) |=> rsp_o.idx_err)
        else $error("guest index past the end accepted");

    a_nat_ro_end: assert property ( // [RULE17]
        s_req_past_end(vmfd_pkg::WID_NAT, vmfd_pkg::AREA_RO, vmfd_pkg::CNT_NAT_RO) |=> rsp_o.idx_err)
        else $error("natural exit data index past the end accepted");

    a_nat_gst_end: assert property ( // [RULE18]
        s_req_past_end(vmfd_pkg::WID_NAT, vmfd_pkg::AREA_GST, vmfd_pkg::CNT_NAT_GST) |=> rsp_o.idx_err)
        else $error("natural guest index past the end accepted");

    a_cr3_end: assert property ( // [RULE16]
        s_req_past_end(vmfd_pkg::WID_NAT, vmfd_pkg::AREA_CTL, vmfd_pkg::CNT_NAT_FIX + 9'(CR3_TARGETS))
            |=> rsp_o.idx_err)
        else $error("target value past the last accepted");

    a_cr3_extra: assert property ( // [RULE16]
        s_req(vmfd_pkg::ENC_CR3_TGT0 + 32'h0000_0008)
            |=> (rsp_o.ok == (CR3_TARGETS > vmfd_pkg::CR3_TGT_DEF)))
        else $error("fifth target value handling wrong");

    a_wr_allowed: assert property ( // [RULE23]
        req_valid_i && !req_write_i |=> !rsp_o.wr_deny)
        else $error("read request refused as write");

    a_hi_access: assert property ( // [RULE21]
        req_valid_i && req_enc_i[vmfd_pkg::ACC_BIT] && (req_enc_i[14:13] == vmfd_pkg::WID_64)
            |=> rsp_o.hi_acc && !rsp_o.odd_err)
        else $error("high half access not flagged");

    a_cnt_step: assert property ( // [RULE22]
        req_valid_i && !req_dec.ok && (cnt_reg != 16'hFFFF)
            && !(bus_i.we && (bus_i.addr == vmfd_pkg::REG_CNT))
            |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("invalid decode not counted");

    a_idt_limit: assert property ( // [RULE13]
        s_entry(vmfd_pkg::ENC_GLOBAL_DESCRIPTOR_TABLE_REG_LIM + 32'h0000_0002) |=> entry_valid_o
            && (entry_data_o == ($past(entry_data_i) & vmfd_pkg::LIM_MASK)))
        else $error("interrupt table limit upper bits kept");

    a_entry_pass: assert property ( // [RULE13] [RULE19]
        s_entry(vmfd_pkg::ENC_GLOBAL_DESCRIPTOR_TABLE_REG_LIM + 32'h0000_0004) |=> entry_data_o == $past(entry_data_i))
        else $error("entry data altered on a plain field");

endmodule
`default_nettype wire

/* File: shared/vmfd_pkg.sv */
// Purpose: constants and carriers of the vm control field decoder
// Assumes: 32-bit field encodings, 64-bit field data
// Notes:   offsets, positions, counts and reset values live here
`default_nettype none
package vmfd_pkg;
    // encoding layout
    localparam logic [31:0] RSV_MASK     = 32'hFFFF_9000;
    localparam int unsigned WID_HI       = 14;
    localparam int unsigned WID_LO       = 13;
    localparam int unsigned AREA_HI      = 11;
    localparam int unsigned AREA_LO      = 10;
    localparam int unsigned IDX_HI       = 9;
    localparam int unsigned IDX_LO       = 1;
    localparam int unsigned ACC_BIT      = 0;
    // width and area codes
    localparam logic [1:0]  WID_16       = 2'h0;
    localparam logic [1:0]  WID_64       = 2'h1;
    localparam logic [1:0]  WID_32       = 2'h2;
    localparam logic [1:0]  WID_NAT      = 2'h3;
    localparam logic [1:0]  AREA_CTL     = 2'h0;
    localparam logic [1:0]  AREA_RO      = 2'h1;
    localparam logic [1:0]  AREA_GST     = 2'h2;
    localparam logic [1:0]  AREA_HOST    = 2'h3;
    // field counts per group
    localparam logic [8:0]  CNT_32_CTL   = 9'h010;
    localparam logic [8:0]  CNT_32_RO    = 9'h008;
    localparam logic [8:0]  CNT_32_GST   = 9'h016;
    localparam logic [8:0]  CNT_32_HOST  = 9'h001;
    localparam logic [8:0]  CNT_NAT_FIX  = 9'h004;
    localparam logic [8:0]  CNT_NAT_RO   = 9'h006;
    localparam logic [8:0]  CNT_NAT_GST  = 9'h014;
    localparam int unsigned CR3_TGT_DEF  = 4;
    // indexes with special handling
    localparam logic [8:0]  IDX_TPR_THR  = 9'h00E;
    localparam logic [8:0]  IDX_SEC_CTL  = 9'h00F;
    localparam logic [8:0]  IDX_GLOBAL_DESCRIPTOR_TABLE_REG_LIM = 9'h008;
    localparam logic [8:0]  IDX_INTERRUPT_DESCRIPTOR_TABLE_REG_LIM = 9'h009;
    localparam logic [8:0]  IDX_BASE_LO  = 9'h003;
    localparam logic [8:0]  IDX_BASE_HI  = 9'h006;
    // named encodings
    localparam logic [31:0] ENC_TPR_THR  = 32'h0000_401C;
    localparam logic [31:0] ENC_EXIT_RSN = 32'h0000_4402;
    localparam logic [31:0] ENC_GLOBAL_DESCRIPTOR_TABLE_REG_LIM = 32'h0000_4810;
    localparam logic [31:0] ENC_HOST_CS  = 32'h0000_4C00;
    localparam logic [31:0] ENC_CR3_TGT0 = 32'h0000_6008;
    localparam logic [31:0] ENC_ES_BASE  = 32'h0000_6806;
    // entry masks
    localparam logic [63:0] LIM_MASK     = 64'h0000_0000_0000_FFFF;
    localparam logic [63:0] BASE_MASK    = 64'h0000_0000_FFFF_FFFF;
    // register map
    localparam logic [3:0]  REG_CFG      = 4'h0;
    localparam logic [3:0]  REG_STAT     = 4'h4;
    localparam logic [3:0]  REG_CNT      = 4'h8;
    localparam logic [1:0]  CFG_RST      = 2'h3;
    localparam int unsigned CFG_TPR_BIT  = 0;
    localparam int unsigned CFG_SEC_BIT  = 1;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } vmfd_bus_t;

    typedef struct packed {
        logic       ok;
        logic       rsv_err;
        logic       odd_err;
        logic       idx_err;
        logic       wr_deny;
        logic       hi_acc;
        logic [1:0] width;
        logic [1:0] area;
        logic [8:0] index;
    } vmfd_dec_t;
endpackage
`default_nettype wire

/* File: test/vmfd_core_model.sv */
// Purpose: core-side requester that issues field decode requests
// Assumes: one request pulse at a time, driven right after a rising edge
// Notes:   encoding lines are scrambled once the request is released
`timescale 1ns/1ps
`default_nettype none
module vmfd_core_model (
    input  wire logic   clk_sys_i,
    output logic        req_valid_o,
    output logic        req_write_o,
    output logic [31:0] req_enc_o
);
    initial
    begin
        req_valid_o = 1'b0;
        req_write_o = 1'b0;
        req_enc_o   = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one-cycle request, held until the taking edge
    task automatic issue(input logic [31:0] enc, input logic wr);
        @(posedge clk_sys_i);
        req_valid_o <= 1'b1;
        req_write_o <= wr;
        req_enc_o   <= enc;
        @(posedge clk_sys_i);
        req_valid_o <= 1'b0;
        req_write_o <= ~wr;
        req_enc_o   <= ~enc;
    endtask
endmodule
`default_nettype wire

/* File: test/vm_control_field_decoder_bench.sv */
// Purpose: self-checking bench of the field decoder
// Assumes: core model drives decode requests, bench drives bus and entry
// Notes:   five page-table-base targets to reach the extra encodings
`timescale 1ns/1ps
`default_nettype none
module vm_control_field_decoder_bench;
    localparam int unsigned CR3_N = 5;
    localparam logic [31:0] ENCS [0:27] = '{
        32'h4000, 32'h401E, 32'h4020, 32'h4400, 32'h4402, 32'h440E, 32'h4410,
        32'h4800, 32'h4810, 32'h482A, 32'h482C, 32'h4C00, 32'h4C02, 32'h6000,
        32'h6008, 32'h6010, 32'h6012, 32'h6400, 32'h640A, 32'h640C, 32'h6800,
        32'h6826, 32'h6828, 32'h4001, 32'h6003, 32'h14000, 32'h5000, 32'h2001};
    logic                clk_sys_i;
    logic                nrst_i;
    vmfd_pkg::vmfd_bus_t bus_i;
    logic [31:0]         bus_rdata_o;
    logic                req_valid_i;
    logic                req_write_i;
    logic [31:0]         req_enc_i;
    logic                rsp_valid_o;
    vmfd_pkg::vmfd_dec_t rsp_o;
    logic                entry_valid_i;
    logic [31:0]         entry_enc_i;
    logic [63:0]         entry_data_i;
    logic                entry_valid_o;
    logic [63:0]         entry_data_o;
    int                  error_cnt;
    int                  check_count;
    int                  bad_cnt;

    vmfd_core_model vmfd_core_model_i (
        .clk_sys_i  (clk_sys_i),
        .req_valid_o(req_valid_i),
        .req_write_o(req_write_i),
        .req_enc_o  (req_enc_i)
    );

    vmfd_decoder #(.CR3_TARGETS(CR3_N)) vmfd_decoder_i (
        .clk_sys_i    (clk_sys_i),
        .nrst_i       (nrst_i),
        .bus_i        (bus_i),
        .bus_rdata_o  (bus_rdata_o),
        .req_valid_i  (req_valid_i),
        .req_write_i  (req_write_i),
        .req_enc_i    (req_enc_i),
        .rsp_valid_o  (rsp_valid_o),
        .rsp_o        (rsp_o),
        .entry_valid_i(entry_valid_i),
        .entry_enc_i  (entry_enc_i),
        .entry_data_i (entry_data_i),
        .entry_valid_o(entry_valid_o),
        .entry_data_o (entry_data_o)
    );

    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        bus_i.addr  <= a;
        bus_i.wdata <= d;
        bus_i.we    <= 1'b1;
        @(posedge clk_sys_i);
        bus_i.we    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys_i);
        bus_i.addr <= a;
        bus_i.re   <= 1'b1;
        @(posedge clk_sys_i);
        bus_i.re   <= 1'b0;
        #1;
        chk(what, exp, bus_rdata_o);
        @(posedge clk_sys_i);
        #1;
        chk("rdata after", 0, bus_rdata_o);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // expected validity from width, area, index and capabilities
    function automatic logic exp_ok(input logic [31:0] e, input logic [1:0] cfg);
        logic [8:0] lim;
        logic       c32;
        c32 = (e[14:13] == 2'h2) && (e[11:10] == 2'h0);
        case ({e[14:13], e[11:10]})
            4'h8:    lim = 9'h010;
            4'h9:    lim = 9'h008;
            4'hA:    lim = 9'h016;
            4'hB:    lim = 9'h001;
            4'hC:    lim = 9'(4 + CR3_N);
            4'hD:    lim = 9'h006;
            4'hE:    lim = 9'h014;
            default: lim = 9'h000;
        endcase
        return ((e & 32'hFFFF_9000) == 32'h0) && !e[0] && (e[9:1] < lim)
            && !(c32 && e[9:1] == 9'h00E && !cfg[0]) && !(c32 && e[9:1] == 9'h00F && !cfg[1]);
    endfunction

    task automatic dec(input logic [31:0] e, input logic wr, input logic [1:0] cfg);
        int   n;
        logic ok;
        ok = exp_ok(e, cfg);
        vmfd_core_model_i.issue(e, wr);
        #1;
        for (n = 0; n < 4 && rsp_valid_o !== 1'b1; n++)
        begin
            @(posedge clk_sys_i);
            #1;
        end
        if (n == 4)
        begin
            error_cnt++;
            $display("[ERR] rsp_valid expected 1 seen none");
            close_out();
        end
        chk("latency", 0, n);
        chk("ok", ok, rsp_o.ok);
        chk("width", e[14:13], rsp_o.width);
        chk("area", e[11:10], rsp_o.area);
        chk("index", e[9:1], rsp_o.index);
        if ((e & 32'hFFFF_9000) != 32'h0)
            chk("rsv_err", 1, rsp_o.rsv_err);
        else if (e[0] && e[14])
            chk("odd_err", 1, rsp_o.odd_err);
        else if (e[0] && e[14:13] == 2'h1)
            chk("hi_acc", 1, rsp_o.hi_acc);
        if (((e & 32'hFFFF_9000) == 32'h0) && !e[0])
            chk("idx_err", !ok, rsp_o.idx_err);
        if (ok)
            chk("wr_deny", wr && e[11:10] == 2'h1, rsp_o.wr_deny);
        else
            bad_cnt++;
        @(posedge clk_sys_i);
        #1;
        chk("rsp_valid after", 0, rsp_valid_o);
    endtask

    task automatic ent(input logic [31:0] e, input logic [63:0] d);
        logic [63:0] x;
        x = d;
        if (e == 32'h4810 || e == 32'h4812)
            x = d & 64'h0000_0000_0000_FFFF;
        if (e >= 32'h6806 && e <= 32'h680C)
            x = d & 64'h0000_0000_FFFF_FFFF;
        @(posedge clk_sys_i);
        entry_valid_i <= 1'b1;
        entry_enc_i   <= e;
        entry_data_i  <= d;
        @(posedge clk_sys_i);
        entry_valid_i <= 1'b0;
        entry_enc_i   <= ~e;
        entry_data_i  <= ~d;
        #1;
        chk("entry valid", 1, entry_valid_o);
        chk("entry data", x, entry_data_o);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_table;
        foreach (ENCS[i])
            dec(ENCS[i], i[0], 2'h3);
    endtask

    task automatic t_caps;
        reg_wr(4'h0, 32'hFFFF_FFFC);
        reg_rd(4'h0, 32'h0, "cfg cleared");
        dec(32'h401C, 1'b0, 2'h0);
        dec(32'h401E, 1'b1, 2'h0);
        dec(32'h401A, 1'b0, 2'h0);
        dec(32'h4402, 1'b1, 2'h0);
        reg_wr(4'h0, 32'h3);
        dec(32'h401C, 1'b0, 2'h3);
    endtask

    task automatic t_regs;
        reg_rd(4'h8, 32'(bad_cnt), "invalid count");
        reg_rd(4'h4, {13'h0, 6'b100000, 2'h2, 2'h0, 9'h00E}, "status");
        reg_wr(4'h8, 32'h0);
        reg_rd(4'h8, 32'h0, "count cleared");
        reg_rd(4'hC, 32'h0, "unmapped");
    endtask

    task automatic t_entry;
        foreach (ENCS[i])
            if (i < 8)
                ent(32'h4810 + 32'(i * 2), 64'hA5C3_1234_5678_9ABC ^ 64'(i));
        for (int i = 0; i < 6; i++)
            ent(32'h6804 + 32'(i * 2), 64'hF0E1_D2C3_B4A5_9687);
    endtask

    initial
    begin
        error_cnt     = 0;
        check_count   = 0;
        bad_cnt       = 0;
        nrst_i        = 1'b0;
        bus_i         = '0;
        entry_valid_i = 1'b0;
        entry_enc_i   = 32'h0;
        entry_data_i  = 64'h0;
        repeat (5) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        reg_rd(4'h0, 32'h3, "cfg reset");
        reg_rd(4'h8, 32'h0, "count reset");
        t_table();
        t_caps();
        t_regs();
        t_entry();
        close_out();
    end
endmodule
`default_nettype wire
